/* File: common/slvm_pkg.sv */
// Package for the supply low-voltage monitor: offsets, fields, resets, timing
package slvm_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] MASK_OFFSET   = 4'h8;
    localparam logic [3:0] FLAGS_OFFSET  = 4'hc;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int THRESH_LSB = 0;
    localparam int THRESH_MSB = 2;
    localparam int ENABLE_BIT = 4;
    localparam int LVOUT_BIT  = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h17;

    // ----------------------------------------
    // Flags register fields
    // ----------------------------------------
    localparam int LVF_BIT  = 0;
    localparam int MFF_BIT  = 1;

    // ----------------------------------------
    // Interrupt status and mask bits
    // ----------------------------------------
    localparam int EV_LVF  = 0;
    localparam int EV_RISE = 1;
    localparam int EV_FALL = 2;
    localparam int EV_W    = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // ----------------------------------------
    // Timing: interrupt delay after the output bit rises
    // ----------------------------------------
    localparam int CLK_MHZ          = 200;
    localparam int INT_DELAY_NS     = 15000;
    localparam int INT_DELAY_CYCLES = (INT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int DLY_W            = 16;

    // Threshold codes, ascending trip levels
    typedef enum logic [2:0] {
        TH_1V8 = 3'h0, TH_2V0 = 3'h1, TH_2V4 = 3'h2, TH_2V7 = 3'h3,
        TH_3V0 = 3'h4, TH_3V3 = 3'h5, TH_3V6 = 3'h6, TH_4V0 = 3'h7
    } slvm_thresh_type;

    // Analog front-end control carried out of the block
    typedef struct packed {
        logic            enable;
        slvm_thresh_type level;
    } slvm_afe_type;

    // Delay sequencer states
    typedef enum logic [1:0] {
        DS_IDLE = 2'h0,
        DS_WAIT = 2'h1,
        DS_HELD = 2'h2
    } slvm_dstate_type;

endpackage : slvm_pkg

/* File: hw/slvm_top.sv */
// Supply low-voltage monitor: control register, status, delayed request, wake
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module slvm_top #(
    parameter int INT_DELAY = slvm_pkg::INT_DELAY_CYCLES
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    // Avalon-MM slave
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    // Power mode and servicing
    input  wire logic         sleep_mode,
    input  wire logic         mf_service,
    // Analog comparator
    input  wire logic         comp_below_async,
    output slvm_pkg::slvm_afe_type afe_ctrl,
    // Events
    output logic              multi_function_request_flag,
    output logic              wake_pulse,
    output logic              irq
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0]                threshold_select_reg;
    logic                      detector_enable_reg;
    logic                      low_voltage_output_reg;
    logic                      low_voltage_request_flag_reg;
    logic [slvm_pkg::EV_W-1:0] status_reg;
    logic [slvm_pkg::EV_W-1:0] mask_reg;
    logic                      sync1_reg;
    logic                      sync2_reg;
    logic                      lvf_prev_reg;
    logic                      ack_reg;
    logic [slvm_pkg::DLY_W-1:0] dly_reg;
    slvm_pkg::slvm_dstate_type  dstate_reg;

    logic                      active;
    logic                      wr_ok;
    logic                      rd_ok;
    logic                      dly_done;
    logic                      rise;
    logic                      fall;
    logic                      sw_lvf_set;
    logic                      sw_lvf_clr;
    logic                      sw_mff_clr;
    logic [7:0]                ctrl_view;

    // Address match helper
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Single-cycle wait then answer: access ends on second edge
    assign wr_ok      = avs_write && ack_reg;
    assign rd_ok      = avs_read && ack_reg;
    assign sw_lvf_set = wr_ok && hit(avs_address, slvm_pkg::FLAGS_OFFSET) && avs_writedata[slvm_pkg::LVF_BIT];
    assign sw_lvf_clr = wr_ok && hit(avs_address, slvm_pkg::FLAGS_OFFSET) && !avs_writedata[slvm_pkg::LVF_BIT];
    assign sw_mff_clr = wr_ok && hit(avs_address, slvm_pkg::FLAGS_OFFSET) && !avs_writedata[slvm_pkg::MFF_BIT];

    // Detector powered only when enabled and awake
    assign active = detector_enable_reg && !sleep_mode;

    // Unimplemented bits forced to zero
    assign ctrl_view = {2'b00, low_voltage_output_reg, detector_enable_reg, 1'b0, threshold_select_reg};

    // Edges of the synchronised output
    assign rise     = sync2_reg && !low_voltage_output_reg;
    assign fall     = !sync2_reg && low_voltage_output_reg;
    assign dly_done = (dstate_reg == slvm_pkg::DS_WAIT) && (dly_reg == slvm_pkg::DLY_W'(INT_DELAY - 1));

    // ----------------------------------------
    // Avalon handshake
    // ----------------------------------------
    // Waitrequest low for exactly one cycle per access
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // Readback mux
    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && !ack_reg) begin
            case (avs_address)
                slvm_pkg::CTRL_OFFSET:   avs_readdata <= {24'h00_0000, ctrl_view};
                slvm_pkg::STATUS_OFFSET: avs_readdata <= {29'h0, status_reg};
                slvm_pkg::MASK_OFFSET:   avs_readdata <= {29'h0, mask_reg};
                slvm_pkg::FLAGS_OFFSET:  avs_readdata <= {30'h0, multi_function_request_flag,
                                                          low_voltage_request_flag_reg};
                default:                 avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Waitrequest from a flop, the inverse of the next value of ack_reg
    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            threshold_select_reg <= slvm_pkg::CTRL_RESET[slvm_pkg::THRESH_MSB:slvm_pkg::THRESH_LSB];
            detector_enable_reg  <= slvm_pkg::CTRL_RESET[slvm_pkg::ENABLE_BIT];
        end else if (wr_ok && hit(avs_address, slvm_pkg::CTRL_OFFSET)) begin
            threshold_select_reg <= avs_writedata[slvm_pkg::THRESH_MSB:slvm_pkg::THRESH_LSB];
            detector_enable_reg  <= avs_writedata[slvm_pkg::ENABLE_BIT];
        end
    end

    // Front-end control
    always_ff @(posedge mclk) begin
        if (srst) begin
            afe_ctrl <= '0;
        end else begin
            afe_ctrl.enable <= active;
            afe_ctrl.level  <= slvm_pkg::slvm_thresh_type'(threshold_select_reg);
        end
    end

    // ----------------------------------------
    // Comparator synchroniser and output bit
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= comp_below_async && active;
            sync2_reg <= sync1_reg;
        end
    end

    // Output bit tracks the comparison each cycle, no filtering
    always_ff @(posedge mclk) begin
        if (srst) begin
            low_voltage_output_reg <= slvm_pkg::CTRL_RESET[slvm_pkg::LVOUT_BIT];
        end else begin
            low_voltage_output_reg <= sync2_reg && active;
        end
    end

    // ----------------------------------------
    // Interrupt delay sequencer
    // ----------------------------------------
    // Counts from rise; a drop before the end restarts the wait
    always_ff @(posedge mclk) begin
        if (srst) begin
            dstate_reg <= slvm_pkg::DS_IDLE;
            dly_reg    <= '0;
        end else begin
            case (dstate_reg)
                slvm_pkg::DS_IDLE: begin
                    dly_reg <= '0;
                    if (rise) begin
                        dstate_reg <= slvm_pkg::DS_WAIT;
                    end
                end
                slvm_pkg::DS_WAIT: begin
                    if (!low_voltage_output_reg) begin
                        dstate_reg <= slvm_pkg::DS_IDLE;
                    end else if (dly_done) begin
                        dstate_reg <= slvm_pkg::DS_HELD;
                    end else begin
                        dly_reg <= dly_reg + 1'b1;
                    end
                end
                slvm_pkg::DS_HELD: begin
                    if (!low_voltage_output_reg) begin
                        dstate_reg <= slvm_pkg::DS_IDLE;
                    end
                end
                default: dstate_reg <= slvm_pkg::DS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Request flags
    // ----------------------------------------
    // Low-voltage flag: set by delay or software, hardware set wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            low_voltage_request_flag_reg <= 1'b0;
        end else if (dly_done && low_voltage_output_reg) begin
            low_voltage_request_flag_reg <= 1'b1;
        end else if (sw_lvf_set) begin
            low_voltage_request_flag_reg <= 1'b1;
        end else if (sw_lvf_clr) begin
            low_voltage_request_flag_reg <= 1'b0;
        end
    end

    // Group flag: cleared by service or software only
    always_ff @(posedge mclk) begin
        if (srst) begin
            multi_function_request_flag <= 1'b0;
        end else if (low_voltage_request_flag_reg && !lvf_prev_reg) begin
            multi_function_request_flag <= 1'b1;
        end else if (mf_service || sw_mff_clr) begin
            multi_function_request_flag <= 1'b0;
        end
    end

    // Wake on every flag rise regardless of mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            lvf_prev_reg <= 1'b0;
            wake_pulse   <= 1'b0;
        end else begin
            lvf_prev_reg <= low_voltage_request_flag_reg;
            wake_pulse   <= low_voltage_request_flag_reg && !lvf_prev_reg;
        end
    end

    // ----------------------------------------
    // Sticky status, mask and interrupt line
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg
                           & ~((wr_ok && hit(avs_address, slvm_pkg::STATUS_OFFSET))
                               ? avs_writedata[slvm_pkg::EV_W-1:0] : 3'h0))
                          | {fall, rise, (low_voltage_request_flag_reg && !lvf_prev_reg)};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_reg <= slvm_pkg::MASK_RESET;
        end else if (wr_ok && hit(avs_address, slvm_pkg::MASK_OFFSET)) begin
            mask_reg <= avs_writedata[slvm_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

endmodule : slvm_top

/* File: verification/slvm_top_asserts.sv */
// Port-level checks for the supply low-voltage monitor
`timescale 1ns/1ps
module slvm_top_asserts #(
    parameter int INT_DELAY = slvm_pkg::INT_DELAY_CYCLES
) (
    input wire logic                   mclk,
    input wire logic                   srst,
    input wire logic [3:0]             avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_writedata,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic                   sleep_mode,
    input wire logic                   mf_service,
    input wire logic                   comp_below_async,
    input wire slvm_pkg::slvm_afe_type afe_ctrl,
    input wire logic                   multi_function_request_flag,
    input wire logic                   wake_pulse,
    input wire logic                   irq
);
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    wire        ctrl_wr = avs_write && !avs_waitrequest && avs_address == slvm_pkg::CTRL_OFFSET;
    wire        ctrl_rd = avs_read && !avs_waitrequest && avs_address == slvm_pkg::CTRL_OFFSET;
    wire        flag_wr = avs_write && !avs_waitrequest && avs_address == slvm_pkg::FLAGS_OFFSET;
    // Run lengths of the powered comparator input, high and low
    always_ff @(posedge mclk) begin
        if (srst || !(comp_below_async && afe_ctrl.enable)) hi_cnt <= 8'h00;
        else hi_cnt <= hi_cnt + {7'h00, hi_cnt != 8'hff};
        if (srst || (comp_below_async && afe_ctrl.enable)) lo_cnt <= 8'h00;
        else lo_cnt <= lo_cnt + {7'h00, lo_cnt != 8'hff};
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    property p_level; ctrl_wr |=> ##1 afe_ctrl.level == $past(avs_writedata[2:0], 2); endproperty
    a_level: assert property (p_level) else $error("threshold not applied");
    property p_enable;
        ctrl_wr && !sleep_mode ##1 !sleep_mode |=> afe_ctrl.enable == $past(avs_writedata[slvm_pkg::ENABLE_BIT], 2);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not applied");
    property p_sleep; sleep_mode |=> !afe_ctrl.enable; endproperty
    a_sleep: assert property (p_sleep) else $error("detector on in sleep");
    property p_rsvd; ctrl_rd |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[3]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_lv_hi; ctrl_rd && hi_cnt >= 8'h08 |-> avs_readdata[slvm_pkg::LVOUT_BIT]; endproperty
    a_lv_hi: assert property (p_lv_hi) else $error("output bit low on low supply");
    property p_lv_lo; ctrl_rd && lo_cnt >= 8'h08 |-> !avs_readdata[slvm_pkg::LVOUT_BIT]; endproperty
    a_lv_lo: assert property (p_lv_lo) else $error("output bit stuck high");
    property p_wake; wake_pulse |=> !wake_pulse; endproperty
    a_wake: assert property (p_wake) else $error("wake longer than a cycle");
    property p_service;
        mf_service && lo_cnt >= 8'h08 && !flag_wr && !$past(flag_wr) |=> !multi_function_request_flag;
    endproperty
    a_service: assert property (p_service) else $error("group flag not cleared");
    c_wake: cover property (wake_pulse);
    c_irq: cover property (irq);
    c_lv: cover property (ctrl_rd && avs_readdata[slvm_pkg::LVOUT_BIT]);
endmodule : slvm_top_asserts
bind slvm_top slvm_top_asserts #(.INT_DELAY(INT_DELAY)) i_slvm_top_asserts (.mclk(mclk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
    .mf_service(mf_service), .comp_below_async(comp_below_async), .afe_ctrl(afe_ctrl),
    .multi_function_request_flag(multi_function_request_flag), .wake_pulse(wake_pulse), .irq(irq));

/* File: verification/slvm_top_tb_top.sv */
// Self-checking bench for the supply low-voltage monitor
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module slvm_top_tb_top;
    localparam int ID = 5;
    logic                   mclk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, sleep = 1'b0, svc = 1'b0, comp = 1'b0;
    logic [3:0]             addr = 4'h0;
    logic [31:0]            wdata = 32'h0, seed = 32'h44, rdata, e;
    logic                   wait_rq, mf_flag, wake, irq;
    slvm_pkg::slvm_afe_type afe;
    logic [31:0]            exp_q[$];
    int                     bad_count = 0, cmp_count = 0;
    always #2.5 mclk = ~mclk;
    slvm_top #(.INT_DELAY(ID)) i_slvm_top (.mclk(mclk), .srst(srst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_rq), .sleep_mode(sleep),
        .mf_service(svc), .comp_below_async(comp), .afe_ctrl(afe), .multi_function_request_flag(mf_flag),
        .wake_pulse(wake), .irq(irq));
    // Watcher: each read answer against the oldest note
    always @(posedge mclk) begin
        if (rd === 1'b1 && wait_rq === 1'b0) begin
            e = exp_q.pop_front();
            `CHK("readdata", e, rdata)
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // Bus cycle: hold until waitrequest sampled low at a rising edge, release, one idle edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin @(posedge mclk); n++; end while (wait_rq !== 1'b0 && n < 20);
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin bad_count++; report_and_stop(); end
        @(posedge mclk);
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask : rdc
    // Count wake pulses over n edges, noting the first
    task automatic watch(input int n, output int hits, output int first);
        hits = 0;
        first = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge mclk);
            if (wake === 1'b1) begin if (hits == 0) first = i; hits++; end
        end
    endtask : watch
    initial begin
        #200000 bad_count++;
        report_and_stop();
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        int          h, f;
        logic [31:0] r;
        tick(16);
        srst <= 1'b0;
        tick(1);
        for (int a = 0; a < 16; a += 2) rdc(4'(a), 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            r = xs();
            bus(1'b1, slvm_pkg::CTRL_OFFSET, {r[31:5], 1'b1, r[3], 3'(c)});
            tick(1);
            `CHK("afe_level", 3'(c), afe.level)
            `CHK("afe_enable", 1'b1, afe.enable)
            rdc(slvm_pkg::CTRL_OFFSET, 32'h10 | 32'(c));
        end
        bus(1'b1, slvm_pkg::CTRL_OFFSET, 32'h3);
        tick(1);
        `CHK("afe_off", 1'b0, afe.enable)
        bus(1'b1, slvm_pkg::CTRL_OFFSET, 32'h13);
        tick(4);
        $display("test thresholds done");
        repeat (3) begin comp <= 1'b1; tick(2); comp <= 1'b0; tick(8); end
        rdc(slvm_pkg::FLAGS_OFFSET, 32'h0);
        rdc(slvm_pkg::STATUS_OFFSET, 32'h6);
        bus(1'b1, slvm_pkg::STATUS_OFFSET, 32'h7);
        rdc(slvm_pkg::STATUS_OFFSET, 32'h0);
        $display("test glitch done");
        comp <= 1'b1;
        watch(ID + 12, h, f);
        `CHK("wake_count", 1, h)
        `CHK("wake_delay", 1'b1, f > ID + 2 && f <= ID + 8)
        `CHK("irq_masked", 1'b0, irq)
        rdc(slvm_pkg::FLAGS_OFFSET, 32'h3);
        rdc(slvm_pkg::CTRL_OFFSET, 32'h33);
        bus(1'b1, slvm_pkg::MASK_OFFSET, 32'h1);
        tick(2);
        `CHK("irq_on", 1'b1, irq)
        svc <= 1'b1;
        tick(1);
        svc <= 1'b0;
        tick(1);
        `CHK("group_flag", 1'b0, mf_flag)
        rdc(slvm_pkg::FLAGS_OFFSET, 32'h1);
        bus(1'b1, slvm_pkg::FLAGS_OFFSET, 32'h0);
        comp <= 1'b0;
        tick(8);
        bus(1'b1, slvm_pkg::STATUS_OFFSET, 32'h7);
        tick(2);
        `CHK("irq_off", 1'b0, irq)
        $display("test event done");
        bus(1'b1, slvm_pkg::FLAGS_OFFSET, 32'h1);
        comp <= 1'b1;
        watch(ID + 12, h, f);
        `CHK("wake_guard", 1, h)
        comp <= 1'b0;
        bus(1'b1, slvm_pkg::FLAGS_OFFSET, 32'h0);
        tick(10);
        svc <= 1'b1;
        tick(1);
        svc <= 1'b0;
        tick(1);
        `CHK("group_clear", 1'b0, mf_flag)
        $display("test guard done");
        sleep <= 1'b1;
        comp <= 1'b1;
        tick(2);
        `CHK("afe_sleep", 1'b0, afe.enable)
        rdc(slvm_pkg::CTRL_OFFSET, 32'h13);
        sleep <= 1'b0;
        comp <= 1'b0;
        $display("test sleep done");
        report_and_stop();
    end
endmodule : slvm_top_tb_top
